// >>> coil_wave_step.sv
// One coil's incremental current value with quadrant mirroring
module coil_wave_step
   import wave_pkg::*;
#(
   parameter logic [7:0] RESET_MAG = 8'h00
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic stepEn,
   input wire logic stepDown,
   input wire logic reload,
   input wire logic [9:0] phase,
   input wire logic signed [2:0] inc,
   input wire logic [7:0] startVal,
   output current_t current
);

   logic signed [9:0] mag;
   logic signed [9:0] next_mag;
   current_t next_current;
   logic [9:0] nextPhase;
   logic [9:0] base;
   logic [9:0] signPhase;

   // Odd quadrants walk the table backwards, so the step sign flips
   always_comb begin
      nextPhase = stepDown ? phase - 10'h001 : phase + 10'h001;
      base = stepDown ? nextPhase : phase;
      signPhase = stepEn ? nextPhase : phase;
      next_mag = mag;
      if (reload) begin
         next_mag = $signed({2'b00, startVal});
      end else if (stepEn) begin
         if (base[8] ^ stepDown) begin
            next_mag = mag - 10'(inc);
         end else begin
            next_mag = mag + 10'(inc);
         end
      end
      next_current = signPhase[9] ? -next_mag : next_mag;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mag <= $signed({2'b00, RESET_MAG});
         current <= $signed({2'b00, RESET_MAG});
      end else begin
         mag <= next_mag;
         current <= next_current;
      end
   end

   step_incr_a: assert property (@(posedge clk) disable iff (srst)
      stepEn && !reload && !(base[8] ^ stepDown)
      |=> mag == $past(mag) + 10'($past(inc)))
      else $error("magnitude did not add the step increment");

endmodule : coil_wave_step

// >>> drv_shift_reg.sv
// Datagram shifter and answer capture for the driver link
module drv_shift_reg (
   input wire logic clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [31:0] word,
   input wire logic shift,
   input wire logic sample,
   input wire logic last,
   input wire logic dataIn,
   output logic dataOut,
   output logic [31:0] rxWord,
   output logic rxValid
);

   logic [31:0] txReg;
   logic [31:0] rxReg;
   logic [31:0] next_txReg;
   logic [31:0] next_rxReg;
   logic [31:0] next_rxWord;

   // Transmit leaves from bit 31, answer enters at bit 0
   always_comb begin
      next_txReg = txReg;
      next_rxReg = rxReg;
      next_rxWord = rxWord;
      if (load) begin
         next_txReg = word;
         next_rxReg = 32'h00000000;
      end else if (shift) begin
         next_txReg = {txReg[30:0], 1'b0};
      end
      if (sample) begin
         next_rxReg = {rxReg[30:0], dataIn};
         if (last) begin
            next_rxWord = {rxReg[30:0], dataIn};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         txReg <= 32'hffffffff;
         rxReg <= 32'h00000000;
         rxWord <= 32'h00000000;
         rxValid <= 1'b0;
         dataOut <= 1'b1;
      end else begin
         txReg <= next_txReg;
         rxReg <= next_rxReg;
         rxWord <= next_rxWord;
         rxValid <= sample && last;
         dataOut <= next_txReg[31];
      end
   end

endmodule : drv_shift_reg

// >>> drv_slave_model.sv
// Behavioural serial slave standing on the driver link
module drv_slave_model (
   input wire logic clk,
   input wire logic drvSelectN,
   input wire logic drvSclkOut,
   input wire logic drvDataOut,
   input wire logic [7:0] respWord,
   output logic drvDataIn,
   output logic [7:0] gotWord
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Slave shift logic
   logic pSclk = 1'b1;
   int idx = 7;
   initial drvDataIn = 1'b1;
   initial gotWord = 8'h00;

   // Answer changes on falling clock, capture on rising clock
   always @(posedge clk) begin
      if (drvSelectN) begin
         idx <= 7;
         // Released line toggles so a stale bit is never read as valid
         drvDataIn <= ~drvDataIn;
      end else if (pSclk && !drvSclkOut) begin
         drvDataIn <= respWord[idx];
         idx <= idx - 1;
      end else if (!pSclk && drvSclkOut) begin
         gotWord <= {gotWord[6:0], drvDataOut};
      end
      pSclk <= drvSclkOut;
   end
endmodule : drv_slave_model

// >>> microstep_wave_driver.sv
// Microstep current waves and driver link master with registers
//
// Added by the designer: the strobed register port.
`include "wave_params.svh"

module microstep_wave_driver
   import wave_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [6:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic stepPulse,
   input wire logic stepDown,
   input wire logic sendValid,
   input wire datagram_s sendData,
   output logic sendReady,
   output logic [31:0] rxWord,
   output logic rxValid,
   output logic drvSelectN,
   output logic drvSclkOut,
   output logic drvDataOut,
   input wire logic drvDataIn,
   output current_t coilACurrent,
   output current_t coilBCurrent,
   output logic [9:0] microstepIndex
);

   // ==========================================
   // Helpers

   // Zero and one both map to the two-cycle floor
   function automatic logic [3:0] effTime(input logic [3:0] t);
      effTime = (t < `TIME_MIN) ? `TIME_MIN : t;
   endfunction : effTime

   // Quarter-table position for a step, mirrored in odd quadrants
   function automatic logic [7:0] tablePos(input logic [9:0] phase,
      input logic down);
      logic [9:0] base;
      base = down ? phase - 10'h001 : phase;
      tablePos = base[8] ? ~base[7:0] : base[7:0];
   endfunction : tablePos

   // Increment is inclination plus offset bit minus one
   function automatic logic signed [2:0] incAt(input logic [7:0] pos,
      input seg_sel_s seg, input logic [255:0] ofs);
      logic [1:0] w;
      if (pos < seg.borderOne) begin
         w = seg.inclinationZero;
      end else if (pos < seg.borderTwo) begin
         w = seg.inclinationOne;
      end else if (pos < seg.borderThree) begin
         w = seg.inclinationTwo;
      end else begin
         w = seg.inclinationThree;
      end
      incAt = $signed({1'b0, w}) - 3'sd1
         + $signed({2'b00, ofs[pos]});
   endfunction : incAt

   // ==========================================
   // Register file

   logic [31:0] genConfig;
   link_cfg_s linkCfg;
   seg_sel_s segSel;
   logic [31:0] startVals;
   logic [31:0] waveTable [8];
   logic [31:0] next_genConfig;
   link_cfg_s next_linkCfg;
   seg_sel_s next_segSel;
   logic [31:0] next_startVals;
   logic [31:0] next_waveTable [8];
   logic [31:0] next_regRdata;
   logic [255:0] ofsBits;
   logic encSel;

   assign encSel = genConfig[`ENC_OUT_SEL_BIT];

   // Writes land one cycle after the strobe
   always_comb begin
      next_genConfig = genConfig;
      next_linkCfg = linkCfg;
      next_segSel = segSel;
      next_startVals = startVals;
      next_waveTable = waveTable;
      if (regWr) begin
         unique case (regAddr)
            `GEN_CONFIG_ADDR: next_genConfig = regWdata;
            `LINK_CONFIG_ADDR: next_linkCfg = regWdata;
            `SEG_SELECT_ADDR: next_segSel = regWdata;
            `START_VALUES_ADDR:
               next_startVals = regWdata & `START_VALUES_MASK;
            default: begin
               if (regAddr[6:3] == `WAVE_TABLE_ADDR >> 3) begin
                  next_waveTable[regAddr[2:0]] = regWdata;
               end
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_comb begin
      next_regRdata = 32'h00000000;
      if (regRd) begin
         unique case (regAddr)
            `GEN_CONFIG_ADDR: next_regRdata = genConfig;
            `LINK_CONFIG_ADDR: next_regRdata = linkCfg;
            `SEG_SELECT_ADDR: next_regRdata = segSel;
            `STEP_INDEX_ADDR: next_regRdata = {22'h0, microstepIndex};
            `COIL_A_ADDR: next_regRdata = 32'(coilACurrent);
            `COIL_B_ADDR: next_regRdata = 32'(coilBCurrent);
            `START_VALUES_ADDR: next_regRdata = startVals;
            default: begin
               if (regAddr[6:3] == `WAVE_TABLE_ADDR >> 3) begin
                  next_regRdata = waveTable[regAddr[2:0]];
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         genConfig <= `GEN_CONFIG_RESET;
         linkCfg <= `LINK_CONFIG_RESET;
         segSel <= `SEG_SELECT_RESET;
         startVals <= `START_VALUES_RESET;
         for (int i = 0; i < 8; i++) begin
            waveTable[i] <= `WAVE_TABLE_RESET;
         end
         regRdata <= 32'h00000000;
      end else begin
         genConfig <= next_genConfig;
         linkCfg <= next_linkCfg;
         segSel <= next_segSel;
         startVals <= next_startVals;
         waveTable <= next_waveTable;
         regRdata <= next_regRdata;
      end
   end

   // Flat view of the offset bits, word 0 holds positions 0 to 31
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         ofsBits[i*32 +: 32] = waveTable[i];
      end
   end

   // ==========================================
   // Microstep index and coil waves

   logic [9:0] next_microstepIndex;
   logic [9:0] phaseB;
   logic reload;
   logic [7:0] posA;
   logic [7:0] posB;
   logic signed [2:0] incA;
   logic signed [2:0] incB;

   // Coil B leads by a fixed quarter period
   always_comb begin
      next_microstepIndex = microstepIndex;
      if (stepPulse) begin
         next_microstepIndex = stepDown ? microstepIndex - 10'h001
            : microstepIndex + 10'h001;
      end
      reload = stepPulse && (next_microstepIndex == 10'h000);
      phaseB = microstepIndex + `COIL_B_PHASE;
      posA = tablePos(microstepIndex, stepDown);
      posB = tablePos(phaseB, stepDown);
      incA = incAt(posA, segSel, ofsBits);
      incB = incAt(posB, segSel, ofsBits);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         microstepIndex <= 10'h000;
      end else begin
         microstepIndex <= next_microstepIndex;
      end
   end

   coil_wave_step #(
      .RESET_MAG(`START_A_RESET)
   ) coilA (
      .clk(clk),
      .srst(srst),
      .stepEn(stepPulse),
      .stepDown(stepDown),
      .reload(reload),
      .phase(microstepIndex),
      .inc(incA),
      .startVal(startVals[`START_A_LSB +: 8]),
      .current(coilACurrent)
   );

   coil_wave_step #(
      .RESET_MAG(`START_B_RESET)
   ) coilB (
      .clk(clk),
      .srst(srst),
      .stepEn(stepPulse),
      .stepDown(stepDown),
      .reload(reload),
      .phase(phaseB),
      .inc(incB),
      .startVal(startVals[`START_B_LSB +: 8]),
      .current(coilBCurrent)
   );

   // ==========================================
   // Driver link master

   link_state_e state;
   link_state_e next_state;
   logic [3:0] timer;
   logic [3:0] next_timer;
   logic [5:0] bitsLeft;
   logic [5:0] next_bitsLeft;
   logic [5:0] lenEff;
   logic next_sendReady;
   logic accept;
   logic loadTx;
   logic shiftTx;
   logic sampleRx;
   logic lastBit;
   logic dinMeta;
   logic dinSync;
   logic firstBit;

   // Answer pin is asynchronous to clk; two stages before use
   always_ff @(posedge clk) begin
      if (srst) begin
         dinMeta <= 1'b0;
         dinSync <= 1'b0;
      end else begin
         dinMeta <= drvDataIn;
         dinSync <= dinMeta;
      end
   end

   // Zero or oversize lengths send a full word
   assign lenEff = (sendData.bits == 6'h00 || sendData.bits > `WORD_BITS)
      ? `WORD_BITS : sendData.bits;
   assign firstBit = sendData.word[5'(lenEff - 6'h01)];
   assign accept = sendValid && sendReady;

   // Timer reloads with effective count minus one at each phase entry
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_bitsLeft = bitsLeft;
      loadTx = 1'b0;
      shiftTx = 1'b0;
      sampleRx = 1'b0;
      lastBit = 1'b0;
      unique case (state)
         LINK_IDLE: begin
            if (accept) begin
               next_state = LINK_LOW;
               next_timer = effTime(linkCfg.lowTime) - 4'h1;
               next_bitsLeft = lenEff - 6'h01;
               loadTx = 1'b1;
            end
         end
         LINK_LOW: begin
            if (timer == 4'h0) begin
               next_state = LINK_HIGH;
               next_timer = effTime(linkCfg.highTime) - 4'h1;
            end else begin
               next_timer = timer - 4'h1;
            end
         end
         LINK_HIGH: begin
            if (timer == 4'h0) begin
               sampleRx = 1'b1;
               if (bitsLeft == 6'h00) begin
                  lastBit = 1'b1;
                  next_state = LINK_GAP;
                  next_timer = effTime(linkCfg.blockTime) - 4'h1;
               end else begin
                  shiftTx = 1'b1;
                  next_state = LINK_LOW;
                  next_bitsLeft = bitsLeft - 6'h01;
                  next_timer = effTime(linkCfg.lowTime) - 4'h1;
               end
            end else begin
               next_timer = timer - 4'h1;
            end
         end
         LINK_GAP: begin
            if (timer == 4'h0) begin
               next_state = LINK_IDLE;
            end else begin
               next_timer = timer - 4'h1;
            end
         end
      endcase
      // Encoder output mode parks the link; a datagram in flight ends
      next_sendReady = (next_state == LINK_IDLE) && !encSel;
   end

   // Pin levels follow the state they enter so both stay aligned
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= LINK_IDLE;
         timer <= 4'h0;
         bitsLeft <= 6'h00;
         sendReady <= 1'b0;
         drvSelectN <= 1'b1;
         drvSclkOut <= 1'b1;
      end else begin
         state <= next_state;
         timer <= next_timer;
         bitsLeft <= next_bitsLeft;
         sendReady <= next_sendReady;
         drvSelectN <= (next_state == LINK_IDLE)
            || (next_state == LINK_GAP);
         drvSclkOut <= next_state != LINK_LOW;
      end
   end

   drv_shift_reg shifter (
      .clk(clk),
      .srst(srst),
      .load(loadTx),
      .word(sendData.word << (`WORD_BITS - lenEff)),
      .shift(shiftTx),
      .sample(sampleRx),
      .last(lastBit),
      .dataIn(dinSync),
      .dataOut(drvDataOut),
      .rxWord(rxWord),
      .rxValid(rxValid)
   );

   // ==========================================
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence enterLow;
      state == LINK_LOW && $past(state) != LINK_LOW;
   endsequence

   sequence enterHigh;
      state == LINK_HIGH && $past(state) != LINK_HIGH;
   endsequence

   sequence enterGap;
      state == LINK_GAP && $past(state) != LINK_GAP;
   endsequence

   reload_start_a: assert property (
      stepPulse && next_microstepIndex == 10'h000
      |=> coilACurrent == $signed({2'b00, $past(startVals[7:0])}))
      else $error("coil A did not reload its start value");

   cos_start_a: assert property (
      stepPulse && next_microstepIndex == 10'h000
      |=> coilBCurrent == $signed({2'b00, $past(startVals[23:16])}))
      else $error("coil B did not start at quarter period value");

   seg_reset_a: assert property (
      $past(srst) |-> segSel == `SEG_SELECT_RESET)
      else $error("segment select reset value wrong");

   start_reset_a: assert property (
      $past(srst) |-> startVals == `START_VALUES_RESET)
      else $error("start values reset wrong");

   default_inc_a: assert property (
      segSel == `SEG_SELECT_RESET
      |-> (posA < 8'h80) ? (incA == 3'sd1 || incA == 3'sd2)
         : (incA == 3'sd0 || incA == 3'sd1))
      else $error("default segment increment out of range");

   idle_pins_a: assert property (
      state == LINK_IDLE || state == LINK_GAP
      |-> drvSelectN && drvSclkOut)
      else $error("clock or select low between datagrams");

   low_time_a: assert property (
      enterLow |-> timer == effTime($past(linkCfg.lowTime)) - 4'h1)
      else $error("clock low phase length wrong");

   high_time_a: assert property (
      enterHigh |-> timer == effTime($past(linkCfg.highTime)) - 4'h1)
      else $error("clock high phase length wrong");

   gap_time_a: assert property (
      enterGap |-> timer == effTime($past(linkCfg.blockTime)) - 4'h1)
      else $error("gap after datagram length wrong");

   min_phase_a: assert property (
      $fell(drvSclkOut) |=> !drvSclkOut)
      else $error("clock low phase shorter than two cycles");

   msb_first_a: assert property (
      accept |=> !drvSelectN && drvDataOut == $past(firstBit))
      else $error("first bit out is not the most significant");

   enc_block_a: assert property (
      encSel && $past(encSel) |-> !sendReady)
      else $error("link offered while encoder output selected");

   rx_capture_a: assert property (
      rxValid |-> state == LINK_GAP && $past(state) == LINK_HIGH)
      else $error("answer not captured at datagram end");

endmodule : microstep_wave_driver

// >>> tb_top.sv
// Self-checking bench for the microstep wave and driver link block
`include "wave_params.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   miscompares++; $display("ERROR %0t: got %h want %h", $time, a, b); \
   end end

module tb_top
   import wave_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================
   // Signals
   logic clk = 1'b0, srst, regWr, regRd, stepPulse, stepDown, sendValid;
   logic [6:0] regAddr;
   logic [31:0] regWdata, regRdata, rxWord;
   datagram_s sendData;
   logic sendReady, rxValid, drvSelectN, drvSclkOut, drvDataOut, drvDataIn;
   current_t coilACurrent, coilBCurrent;
   logic [9:0] microstepIndex;
   logic [7:0] resp = 8'h3c, gotWord;
   int miscompares = 0, total_checks = 0, cycles = 0;
   int run = 0, lowLen = 0, highLen = 0, gapLen = 0;
   logic pSclk = 1'b1, pSel = 1'b1;
   logic [31:0] cfgs [4] = '{32'h54300000, 32'h0, 32'h11100000, 32'hfff00000};
   int eL [4] = '{3, 2, 2, 15};
   int eH [4] = '{4, 2, 2, 15};
   int eG [4] = '{5, 2, 2, 15};

   always #25 clk = ~clk;

   microstep_wave_driver u_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .stepPulse(stepPulse), .stepDown(stepDown),
      .sendValid(sendValid), .sendData(sendData), .sendReady(sendReady),
      .rxWord(rxWord), .rxValid(rxValid), .drvSelectN(drvSelectN),
      .drvSclkOut(drvSclkOut), .drvDataOut(drvDataOut),
      .drvDataIn(drvDataIn), .coilACurrent(coilACurrent),
      .coilBCurrent(coilBCurrent), .microstepIndex(microstepIndex));

   drv_slave_model u_slave (.clk(clk), .drvSelectN(drvSelectN),
      .drvSclkOut(drvSclkOut), .drvDataOut(drvDataOut), .respWord(resp),
      .drvDataIn(drvDataIn), .gotWord(gotWord));

   // ==========================================
   // Link monitor: phase run lengths, idle levels
   always @(posedge clk) begin
      if (drvSclkOut !== pSclk || drvSelectN !== pSel) begin
         if (pSel === 1'b0 && pSclk === 1'b0) lowLen = run;
         else if (pSel === 1'b0) highLen = run;
         else gapLen = run;
         run = 1;
      end else run++;
      pSclk = drvSclkOut;
      pSel = drvSelectN;
      if (srst === 1'b0 && drvSelectN === 1'b1) `CHK(drvSclkOut, 1'b1)
   end

   // Hang guard, far above the longest expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         give_verdict();
      end
   end

   // ==========================================
   // Bus tasks
   task wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   task rd(input logic [6:0] a, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 `CHK(regRdata, e)
   endtask : rd

   // Back-to-back step pulses, settled one cycle after the last
   task step(input int n, input logic dn);
      @(posedge clk);
      repeat (n) begin
         stepDown <= dn;
         stepPulse <= 1'b1;
         @(posedge clk);
      end
      stepPulse <= 1'b0;
      @(posedge clk);
      #1;
   endtask : step

   // Two back-to-back 8-bit datagrams under one timing setting
   task link_test(input logic [31:0] cfg, input int l, h, g);
      int seen;
      wr(`LINK_CONFIG_ADDR, cfg);
      @(posedge clk);
      sendData <= '{word: 32'h000000a5, bits: 6'h08};
      sendValid <= 1'b1;
      seen = 0;
      for (int k = 0; k < 3000 && seen < 2; k++) begin
         @(posedge clk);
         #1 if (rxValid === 1'b1) seen++;
      end
      @(posedge clk);
      sendValid <= 1'b0;
      `CHK(seen, 2)
      `CHK(lowLen, l)
      `CHK(highLen, h)
      `CHK(gapLen >= g, 1'b1)
      `CHK(gotWord, 8'ha5)
      `CHK(rxWord[7:0], resp)
   endtask : link_test

   task give_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   // ==========================================
   // Main sequence
   initial begin
      srst = 1'b1;
      {regWr, regRd, stepPulse, stepDown, sendValid} = 5'h00;
      regAddr = 7'h00;
      regWdata = 32'h0;
      sendData = '0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      #1 `CHK(coilBCurrent, 10'h0f7)
      rd(`SEG_SELECT_ADDR, `SEG_SELECT_RESET);
      rd(`START_VALUES_ADDR, 32'h00f70000);
      rd(`COIL_A_ADDR, 32'h0);
      rd(`STEP_INDEX_ADDR, 32'h0);
      rd(`GEN_CONFIG_ADDR, 32'h0);
      rd(7'h10, 32'h0);
      wr(`STEP_INDEX_ADDR, 32'h5);
      rd(`STEP_INDEX_ADDR, 32'h0);
      wr(`START_VALUES_ADDR, 32'hffffffff);
      rd(`START_VALUES_ADDR, 32'h00ff00ff);
      // Two-segment standard sine set-up, then back to default
      wr(`SEG_SELECT_ADDR, 32'hffff9956);
      rd(`SEG_SELECT_ADDR, 32'hffff9956);
      wr(`SEG_SELECT_ADDR, 32'hffff8056);
      wr(`START_VALUES_ADDR, 32'h00f70005);
      wr(`WAVE_TABLE_ADDR, 32'hffffffff);
      step(32, 1'b0);
      `CHK(coilACurrent, 10'h040)
      step(96, 1'b0);
      `CHK(coilACurrent, 10'h0a0)
      step(22, 1'b0);
      `CHK(coilACurrent, 10'h0a0)
      rd(`STEP_INDEX_ADDR, 32'h96);
      step(150, 1'b1);
      `CHK(coilACurrent, 10'h005)
      `CHK(coilBCurrent, 10'h0f7)
      // Wrap below zero: last quadrant mirrors and shows a negative value
      step(1, 1'b1);
      `CHK(microstepIndex, 10'h3ff)
      `CHK(coilACurrent, 10'h3f9)
      `CHK(coilBCurrent, 10'h0f7)
      step(1, 1'b0);
      `CHK(microstepIndex, 10'h000)
      `CHK(coilACurrent, 10'h005)
      for (int i = 0; i < 4; i++) link_test(cfgs[i], eL[i], eH[i], eG[i]);
      // Encoder select parks the link
      wr(`GEN_CONFIG_ADDR, 32'h01000000);
      @(posedge clk);
      sendValid <= 1'b1;
      repeat (20) @(posedge clk);
      #1 `CHK(sendReady, 1'b0)
      `CHK(drvSelectN, 1'b1)
      @(posedge clk);
      sendValid <= 1'b0;
      give_verdict();
   end
endmodule : tb_top

// >>> wave_params.svh
// Constants for the microstep wave generator and driver link
// Behaviour
// - First coil wave starts at index 0, second at 256; both fixed.
// - Default start currents are 0 for first coil, 247 for second.
// - Start values sit in bits 7:0 and 23:16 of register 0x7e.
// - Segment select resets to border one 128, inclinations 2 then 1.
// - Each step adds inclination when offset bit is one, else one less.
// - Defaults give +1/+2 below index 128 and 0/+1 from 128 to 255.
// - Driver link works only while encoder select bit 24 is zero.
// - Block is link master: makes clock, select low and data out, samples data in.
// - Driver answer is captured during the same transfer.
// - Clock low phase lasts link config bits 23:20 cycles.
// - Clock high phase lasts link config bits 27:24 cycles.
// - After a datagram, wait at least link config bits 31:28 cycles.
// - Between datagrams clock and select outputs stay high.
// - Each timing field gives 2 to 15 cycles; zero means 2.
// - Quarter table expands symmetrically over 1024 index positions.
// - Both currents reload from start values when a step lands the index on zero.
// - Datagrams go out most significant bit first.
`ifndef WAVE_PARAMS_SVH
`define WAVE_PARAMS_SVH

// ==========================================
// Register offsets
`define GEN_CONFIG_ADDR 7'h00
`define LINK_CONFIG_ADDR 7'h04
`define WAVE_TABLE_ADDR 7'h70
`define SEG_SELECT_ADDR 7'h78
`define STEP_INDEX_ADDR 7'h79
`define COIL_A_ADDR 7'h7a
`define COIL_B_ADDR 7'h7b
`define START_VALUES_ADDR 7'h7e

// ==========================================
// Fields and reset values
`define ENC_OUT_SEL_BIT 24
`define START_A_LSB 0
`define START_B_LSB 16
`define START_VALUES_MASK 32'h00ff00ff
`define START_VALUES_RESET 32'h00f70000
`define START_A_RESET 8'h00
`define START_B_RESET 8'hf7
`define SEG_SELECT_RESET 32'hffff8056
`define LINK_CONFIG_RESET 32'h00000000
`define GEN_CONFIG_RESET 32'h00000000
`define WAVE_TABLE_RESET 32'h00000000

// ==========================================
// Geometry and timing
`define COIL_B_PHASE 10'h100
`define TIME_MIN 4'h2
`define WORD_BITS 6'h20

`endif

// >>> wave_pkg.sv
// Types shared by the wave generator and driver link
package wave_pkg;

   typedef logic signed [9:0] current_t;

   typedef struct packed {
      logic [3:0] blockTime;
      logic [3:0] highTime;
      logic [3:0] lowTime;
      logic [19:0] otherBits;
   } link_cfg_s;

   typedef struct packed {
      logic [7:0] borderThree;
      logic [7:0] borderTwo;
      logic [7:0] borderOne;
      logic [1:0] inclinationThree;
      logic [1:0] inclinationTwo;
      logic [1:0] inclinationOne;
      logic [1:0] inclinationZero;
   } seg_sel_s;

   typedef struct packed {
      logic [31:0] word;
      logic [5:0] bits;
   } datagram_s;

   typedef enum logic [1:0] {
      LINK_IDLE,
      LINK_LOW,
      LINK_HIGH,
      LINK_GAP
   } link_state_e;

endpackage : wave_pkg
